// ==== tcr_defs.vh ====
// Constants for the tuner control register bank: addresses, bit positions and reset values.
`ifndef TCR_DEFS_VH
`define TCR_DEFS_VH

// Serial register addresses (5-bit address field).
`define TCR_ADDR_EVENT 5'h02
`define TCR_ADDR_TUNE 5'h03
`define TCR_ADDR_CTRL 5'h04
`define TCR_ADDR_LIMIT 5'h10

// Serial frame layout: address byte then two data bytes, MSB first.
`define TCR_FRAME_BITS 5'h18
`define TCR_ADDR_BITS 5'h08
`define TCR_WORD_BITS 5'h10

// Reset values.
`define TCR_EVENT_RST 16'h0000
`define TCR_TUNE_RST 16'h8000
`define TCR_CTRL_RST 16'h08D2

// Tuning register fields.
`define TCR_TUNE_SUD 15
`define TCR_TUNE_SM 14
`define TCR_TUNE_FR_MSB 13

// Tuner control register fields.
`define TCR_CTRL_PWR_MSB 15
`define TCR_CTRL_PWR_LSB 14
`define TCR_CTRL_BAND 13
`define TCR_CTRL_SOFT_PORT_SOURCE 12
`define TCR_CTRL_IFCT 11
`define TCR_CTRL_AMUTE 10
`define TCR_CTRL_SOFT_MUTE_ENABLE 9
`define TCR_CTRL_SNC 8
`define TCR_CTRL_HMUTE 7
`define TCR_CTRL_SSL_MSB 6
`define TCR_CTRL_SSL_LSB 5
`define TCR_CTRL_INJ 4
`define TCR_CTRL_MONO 3
`define TCR_CTRL_SWP 2
`define TCR_CTRL_DEEMPH 1
`define TCR_CTRL_STOPF 0

// Power field codes.
`define TCR_PWR_OFF 2'h0
`define TCR_PWR_RADIO 2'h1
`define TCR_PWR_BOTH 2'h3

`endif

// ==== tcr_sync2.v ====
// Two-flop synchroniser for pin inputs of the tuner control register bank.
`timescale 1ns/1ps
module tcr_sync2 #(
  parameter W = 3
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  input wire [W-1:0] rst_val_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // The reset value is all ones at every instance; the value tied to rst_val_i is not used.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end
    else if (ce_i)
    begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;
endmodule // tcr_sync2

// ==== tcr_top.v ====
// Tuner control register bank with its 3-wire serial slave port.
// Operation
// - Event register sits at serial address 02.
// - Bit 15 flags decoded data available.
// - Bit 13 flags decoder sync lost.
// - Bit 12 flags bad IF count.
// - Bit 11 flags level below stop level.
// - Bit 9 flags tuner state machine ready.
// - Bit 8 flags band limit or timeout.
// - Address 03 holds direction, mode, frequency.
// - Power field decodes radio and decoder enables.
// - Bit 13 selects the tuning band.
// - Soft port pin shows ready flag or bit.
// - Bit 11 selects IF count duration.
// - Bits 10 and 7 mute both channels.
// - Bits 9, 8 enable soft mute, noise cancel.
// - Bit 4 injection side, bit 3 mono.
// - Bit 1 selects de-emphasis time constant.
// - Bit 0 stops search on failed count.
// - 16-bit words, MSB first, 5-bit address.
`timescale 1ns/1ps
`include "tcr_defs.vh"
module tcr_top (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire spi_cs_b_i,
  input wire spi_clk_i,
  input wire spi_data_i,
  output wire spi_data_o,
  output wire spi_data_oe_o,
  input wire decoded_block_ready_i,
  input wire sync_lost_i,
  input wire if_count_error_i,
  input wire signal_level_drop_i,
  input wire tuner_ready_i,
  input wire band_limit_i,
  output wire event_irq_b_o,
  output wire soft_port_pin_o,
  output wire search_direction_up_o,
  output wire search_mode_select_o,
  output wire [13:0] frequency_setting_o,
  output wire tune_start_o,
  output wire radio_on_o,
  output wire decoder_on_o,
  output wire band_select_o,
  output wire if_count_duration_o,
  output wire audio_mute_o,
  output wire soft_mute_enable_o,
  output wire noise_cancel_enable_o,
  output wire [1:0] search_stop_level_o,
  output wire injection_side_o,
  output wire force_mono_o,
  output wire deemphasis_select_o,
  output wire stop_on_failed_count_o
);

  // Serial frame sequencer states.
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  // Event register image: flags in the upper byte, masks in the lower.
  function [15:0] event_word;
    input [5:0] flags;
    input [5:0] masks;
    begin
      event_word = {flags[5], 1'b0, flags[4], flags[3], flags[2], 1'b0, flags[1], flags[0],
                    masks[5], 1'b0, masks[4], masks[3], masks[2], 1'b0, masks[1], masks[0]};
    end
  endfunction

  // Only addresses 0 to 15 are recognised by the serial port.
  function addr_known;
    input [4:0] a;
    begin
      addr_known = (a < `TCR_ADDR_LIMIT);
    end
  endfunction

  wire [2:0] pin_sync;
  wire cs_b_s;
  wire sclk_s;
  wire sdi_s;
  wire [5:0] event_in;
  wire sclk_rise;
  wire sclk_fall;
  wire [23:0] frame_next;
  wire addr_byte_done;
  wire frame_done;
  wire [4:0] byte_addr;
  wire byte_rd;
  wire [15:0] wr_word;
  wire wr_event;
  wire wr_tune;
  wire wr_ctrl;
  wire rd_event_clr;

  reg sclk_q_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [4:0] bit_cnt_ff;
  reg [23:0] shift_in_ff;
  reg [15:0] shift_out_ff;
  reg rd_mode_ff;
  reg rd_known_ff;
  reg sdo_ff;
  reg sdo_oe_ff;
  reg [5:0] flags_ff;
  reg [5:0] nxt_flags;
  reg [5:0] masks_ff;
  reg [15:0] tune_ff;
  reg [15:0] ctrl_ff;
  reg tune_start_ff;
  reg irq_b_ff;
  reg soft_port_ff;
  reg radio_on_ff;
  reg decoder_on_ff;
  reg audio_mute_ff;
  reg [15:0] rd_word;

  tcr_sync2 #(
    .W(3)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({spi_cs_b_i, spi_clk_i, spi_data_i}),
    .rst_val_i(3'h7),
    .q_o(pin_sync)
  );

  assign cs_b_s = pin_sync[2];
  assign sclk_s = pin_sync[1];
  assign sdi_s = pin_sync[0];

  assign event_in = {decoded_block_ready_i, sync_lost_i, if_count_error_i,
                     signal_level_drop_i, tuner_ready_i, band_limit_i};

  // Edges are taken from the synchronised copy, never from the first stage.
  assign sclk_rise = sclk_s & ~sclk_q_ff & ~cs_b_s;
  assign sclk_fall = ~sclk_s & sclk_q_ff & ~cs_b_s;

  assign frame_next = {shift_in_ff[22:0], sdi_s};
  assign addr_byte_done = sclk_rise && (state_ff == ST_ADDR) && (bit_cnt_ff == `TCR_ADDR_BITS - 5'h01);
  assign frame_done = sclk_rise && (state_ff == ST_DATA) && (bit_cnt_ff == `TCR_FRAME_BITS - 5'h01);
  assign byte_addr = frame_next[5:1];
  assign byte_rd = frame_next[0];
  assign wr_word = frame_next[15:0];

  // A write frame commits only after all 24 bits have arrived.
  assign wr_event = frame_done && !rd_mode_ff && (frame_next[21:17] == `TCR_ADDR_EVENT);
  assign wr_tune = frame_done && !rd_mode_ff && (frame_next[21:17] == `TCR_ADDR_TUNE);
  assign wr_ctrl = frame_done && !rd_mode_ff && (frame_next[21:17] == `TCR_ADDR_CTRL);

  // Reading the event register clears its flags as the word is captured.
  assign rd_event_clr = addr_byte_done && byte_rd && (byte_addr == `TCR_ADDR_EVENT);

  // Read multiplexer; other recognised addresses belong to other blocks and read zero here.
  always @*
  begin
    rd_word = 16'h0000;
    case (byte_addr)
      `TCR_ADDR_EVENT: rd_word = event_word(flags_ff | event_in, masks_ff);
      `TCR_ADDR_TUNE: rd_word = tune_ff;
      `TCR_ADDR_CTRL: rd_word = ctrl_ff;
      default: rd_word = 16'h0000;
    endcase
  end

  // Frame sequencer.
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        nxt_state = ST_ADDR;
      ST_ADDR:
        if (addr_byte_done)
        begin
          nxt_state = ST_DATA;
        end
      ST_DATA:
        if (frame_done)
        begin
          nxt_state = ST_DONE;
        end
      ST_DONE:
        nxt_state = ST_DONE;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (cs_b_s)
    begin
      nxt_state = ST_IDLE;
    end
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_q_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_in_ff <= 24'h00_0000;
      rd_mode_ff <= 1'b0;
      rd_known_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      sclk_q_ff <= sclk_s;
      state_ff <= nxt_state;
      if (cs_b_s)
      begin
        bit_cnt_ff <= 5'h00;
        rd_mode_ff <= 1'b0;
        rd_known_ff <= 1'b0;
      end
      else if (sclk_rise && (state_ff != ST_DONE))
      begin
        shift_in_ff <= frame_next;
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        if (addr_byte_done)
        begin
          rd_mode_ff <= byte_rd;
          // Whether the address is known is kept here because later data bits shift the address along the shift register.
          rd_known_ff <= addr_known(byte_addr);
        end
      end
    end
  end

  // Read data leaves on falling clock edges, MSB first; unknown addresses keep the line released.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      shift_out_ff <= 16'h0000;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cs_b_s)
      begin
        sdo_oe_ff <= 1'b0;
        sdo_ff <= 1'b0;
      end
      else if (addr_byte_done && byte_rd && addr_known(byte_addr))
      begin
        shift_out_ff <= rd_word;
      end
      else if (sclk_fall && rd_mode_ff && rd_known_ff && (state_ff != ST_ADDR))
      begin
        sdo_oe_ff <= 1'b1;
        sdo_ff <= shift_out_ff[15];
        shift_out_ff <= {shift_out_ff[14:0], 1'b0};
      end
    end
  end

  // Flags: any event seen while the clock enable is high sets its flag, and an event in the clearing cycle still wins.
  always @*
  begin
    nxt_flags = flags_ff;
    if (rd_event_clr)
    begin
      nxt_flags = 6'h00;
    end
    nxt_flags = nxt_flags | event_in;
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flags_ff <= 6'h00;
      masks_ff <= 6'h00;
      tune_ff <= `TCR_TUNE_RST;
      ctrl_ff <= `TCR_CTRL_RST;
      tune_start_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      flags_ff <= nxt_flags;
      tune_start_ff <= wr_tune;
      if (wr_event)
      begin
        masks_ff <= {wr_word[7], wr_word[5], wr_word[4], wr_word[3], wr_word[1], wr_word[0]};
      end
      if (wr_tune)
      begin
        tune_ff <= wr_word;
      end
      if (wr_ctrl)
      begin
        ctrl_ff <= wr_word;
      end
    end
  end

  // Derived outputs are registered so every pin comes straight from a flip-flop.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_b_ff <= 1'b1;
      soft_port_ff <= 1'b0;
      radio_on_ff <= 1'b0;
      decoder_on_ff <= 1'b0;
      audio_mute_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      irq_b_ff <= ~|(nxt_flags & masks_ff);
      // Soft port follows the ready flag or the plain port bit.
      soft_port_ff <= ctrl_ff[`TCR_CTRL_SOFT_PORT_SOURCE] ? nxt_flags[1] : ctrl_ff[`TCR_CTRL_SWP];
      // Code 10 is unused and is treated as fully off.
      radio_on_ff <= (ctrl_ff[`TCR_CTRL_PWR_MSB:`TCR_CTRL_PWR_LSB] == `TCR_PWR_RADIO) ||
                     (ctrl_ff[`TCR_CTRL_PWR_MSB:`TCR_CTRL_PWR_LSB] == `TCR_PWR_BOTH);
      decoder_on_ff <= (ctrl_ff[`TCR_CTRL_PWR_MSB:`TCR_CTRL_PWR_LSB] == `TCR_PWR_BOTH);
      audio_mute_ff <= ctrl_ff[`TCR_CTRL_AMUTE] | ctrl_ff[`TCR_CTRL_HMUTE];
    end
  end

  assign spi_data_o = sdo_ff;
  assign spi_data_oe_o = sdo_oe_ff;
  assign event_irq_b_o = irq_b_ff;
  assign soft_port_pin_o = soft_port_ff;
  assign search_direction_up_o = tune_ff[`TCR_TUNE_SUD];
  assign search_mode_select_o = tune_ff[`TCR_TUNE_SM];
  assign frequency_setting_o = tune_ff[`TCR_TUNE_FR_MSB:0];
  assign tune_start_o = tune_start_ff;
  assign radio_on_o = radio_on_ff;
  assign decoder_on_o = decoder_on_ff;
  assign band_select_o = ctrl_ff[`TCR_CTRL_BAND];
  assign if_count_duration_o = ctrl_ff[`TCR_CTRL_IFCT];
  assign audio_mute_o = audio_mute_ff;
  assign soft_mute_enable_o = ctrl_ff[`TCR_CTRL_SOFT_MUTE_ENABLE];
  assign noise_cancel_enable_o = ctrl_ff[`TCR_CTRL_SNC];
  assign search_stop_level_o = ctrl_ff[`TCR_CTRL_SSL_MSB:`TCR_CTRL_SSL_LSB];
  assign injection_side_o = ctrl_ff[`TCR_CTRL_INJ];
  assign force_mono_o = ctrl_ff[`TCR_CTRL_MONO];
  assign deemphasis_select_o = ctrl_ff[`TCR_CTRL_DEEMPH];
  assign stop_on_failed_count_o = ctrl_ff[`TCR_CTRL_STOPF];

endmodule // tcr_top

// ==== tcr_chk.sv ====
// Port-level assertions for the tuner control register bank.
`timescale 1ns/1ps
module tcr_chk (
  input wire clk_i,
  input wire rst_b_i,
  input wire spi_cs_b_i,
  input wire spi_clk_i,
  input wire spi_data_o,
  input wire spi_data_oe_o,
  input wire decoded_block_ready_i,
  input wire sync_lost_i,
  input wire if_count_error_i,
  input wire signal_level_drop_i,
  input wire tuner_ready_i,
  input wire band_limit_i,
  input wire event_irq_b_o,
  input wire search_direction_up_o,
  input wire search_mode_select_o,
  input wire [13:0] frequency_setting_o,
  input wire tune_start_o,
  input wire radio_on_o,
  input wire decoder_on_o
);
  wire any_ev = decoded_block_ready_i | sync_lost_i | if_count_error_i | signal_level_drop_i | tuner_ready_i
    | band_limit_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_power_decode: assert property (decoder_on_o |-> radio_on_o)
    else $error("decoder enabled while radio is off");
  a_oe_idle: assert property (spi_cs_b_i [*6] |-> !spi_data_oe_o)
    else $error("data line driven while deselected");
  a_oe_start: assert property ($rose(spi_data_oe_o) |-> !spi_cs_b_i && !spi_clk_i)
    else $error("data line driven outside a low serial clock phase");
  a_data_hold: assert property (spi_data_oe_o && $past(spi_data_oe_o) && $changed(spi_data_o) |-> !spi_clk_i)
    else $error("read bit changed while serial clock high");
  a_tune_commit: assert property (tune_start_o |-> !spi_cs_b_i && spi_clk_i)
    else $error("tuning commit outside the last serial bit");
  a_tune_change: assert property ($changed({search_direction_up_o, search_mode_select_o, frequency_setting_o})
    |-> tune_start_o)
    else $error("tuning outputs changed without a commit");
  a_irq_cause: assert property ($fell(event_irq_b_o) |-> $past(any_ev) || !spi_cs_b_i || $past(!spi_cs_b_i))
    else $error("interrupt raised without an event or mask write");
  a_irq_clear: assert property ($rose(event_irq_b_o) |-> !spi_cs_b_i || $past(!spi_cs_b_i))
    else $error("interrupt released without a serial access");
endmodule // tcr_chk
bind tcr_top tcr_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .spi_cs_b_i(spi_cs_b_i), .spi_clk_i(spi_clk_i),
  .spi_data_o(spi_data_o), .spi_data_oe_o(spi_data_oe_o), .decoded_block_ready_i(decoded_block_ready_i),
  .sync_lost_i(sync_lost_i), .if_count_error_i(if_count_error_i), .signal_level_drop_i(signal_level_drop_i),
  .tuner_ready_i(tuner_ready_i), .band_limit_i(band_limit_i), .event_irq_b_o(event_irq_b_o),
  .search_direction_up_o(search_direction_up_o), .search_mode_select_o(search_mode_select_o),
  .frequency_setting_o(frequency_setting_o), .tune_start_o(tune_start_o), .radio_on_o(radio_on_o),
  .decoder_on_o(decoder_on_o));

// ==== tcr_host.sv ====
// Host model that runs 3-wire serial frames against the register bank.
`timescale 1ns/1ps
module tcr_host (
  input wire clk_i,
  input wire line_i,
  output reg cs_b_o,
  output reg sclk_o,
  output reg sdo_o
);
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    sdo_o = 1'b0;
  end
  task automatic xfer(input logic [4:0] a, input logic rw, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] fr;
    begin
      fr = {2'b00, a, rw, wd};
      rd = 16'h0000;
      @(negedge clk_i);
      cs_b_o = 1'b0;
      repeat (10) @(negedge clk_i);
      for (int i = 23; i >= 0; i--)
      begin
        // Once released the line is not left at its last level, so a missing driver shows.
        if (rw && i < 16)
          sdo_o = ~line_i;
        else
          sdo_o = fr[i];
        repeat (10) @(negedge clk_i);
        sclk_o = 1'b1;
        if (i < 16)
          rd = {rd[14:0], line_i};
        repeat (10) @(negedge clk_i);
        sclk_o = 1'b0;
      end
      repeat (10) @(negedge clk_i);
      cs_b_o = 1'b1;
      repeat (8) @(negedge clk_i);
    end
  endtask
endmodule // tcr_host

// ==== tcr_top_tb.sv ====
// Self-checking testbench for the tuner control register bank.
`timescale 1ns/1ps
module tcr_top_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] ev = 6'h00;
  logic oe_seen = 1'b0;
  logic ce = 1'b1;
  int ts_cnt = 0;
  wire ts;
  logic [15:0] m_fl, m_msk, m_tune, m_ctrl, rv, d;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int pos[6] = '{15, 13, 12, 11, 9, 8};
  wire line, dout, doe, cs_b, sclk, hdo, irq_b, sp, search_direction_up, sm, ron, don, band, ifd, amu, smu, noise_cancel_enable, inj, mono, deemphasis_select;
  wire stopf;
  wire [13:0] fr;
  wire [1:0] ssl;
  assign line = doe ? dout : hdo;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (doe)
      oe_seen <= 1'b1;
    if (ts)
      ts_cnt++;
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      tally_and_finish;
    end
  end
  tcr_host host (.clk_i(clk_i), .line_i(line), .cs_b_o(cs_b), .sclk_o(sclk), .sdo_o(hdo));
  tcr_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .spi_cs_b_i(cs_b), .spi_clk_i(sclk),
    .spi_data_i(line), .spi_data_o(dout), .spi_data_oe_o(doe), .decoded_block_ready_i(ev[0]),
    .sync_lost_i(ev[1]), .if_count_error_i(ev[2]), .signal_level_drop_i(ev[3]), .tuner_ready_i(ev[4]),
    .band_limit_i(ev[5]), .event_irq_b_o(irq_b), .soft_port_pin_o(sp), .search_direction_up_o(search_direction_up),
    .search_mode_select_o(sm), .frequency_setting_o(fr), .tune_start_o(ts), .radio_on_o(ron),
    .decoder_on_o(don), .band_select_o(band), .if_count_duration_o(ifd), .audio_mute_o(amu),
    .soft_mute_enable_o(smu), .noise_cancel_enable_o(noise_cancel_enable), .search_stop_level_o(ssl), .injection_side_o(inj),
    .force_mono_o(mono), .deemphasis_select_o(deemphasis_select), .stop_on_failed_count_o(stopf));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    begin
      num_checks++;
      if (got !== exp)
      begin
        errors++;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task automatic chk_outs;
    logic [15:0] e;
    begin
      e = {m_ctrl[14], &m_ctrl[15:14], m_ctrl[13], m_ctrl[11], m_ctrl[10] | m_ctrl[7], m_ctrl[9:8], m_ctrl[6:4],
        m_ctrl[3], m_ctrl[1:0], m_ctrl[12] ? m_fl[9] : m_ctrl[2], ~|(m_fl[15:8] & m_msk[7:0]), 1'b0};
      chk("outputs", e, {ron, don, band, ifd, amu, smu, noise_cancel_enable, ssl, inj, mono, deemphasis_select, stopf, sp, irq_b, 1'b0});
      chk("tuning", m_tune, {search_direction_up, sm, fr});
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] wd);
    begin
      host.xfer(a, 1'b0, wd, rv);
      if (a == 5'h02)
        m_msk = wd & 16'h00BB;
      if (a == 5'h03)
        m_tune = wd;
      if (a == 5'h04)
        m_ctrl = wd;
      repeat (4) @(negedge clk_i);
    end
  endtask
  task automatic rd(input logic [4:0] a);
    begin
      oe_seen = 1'b0;
      host.xfer(a, 1'b1, 16'h0000, rv);
      // An undriven line toggles in the host model, so a refused address reads alternating bits.
      chk("read", a >= 5'h10 ? 16'h5555 : a == 5'h02 ? m_fl | m_msk : a == 5'h03 ? m_tune :
        a == 5'h04 ? m_ctrl : 16'h0000, rv);
      if (a == 5'h02)
        m_fl = 16'h0000;
      repeat (4) @(negedge clk_i);
    end
  endtask
  task automatic evt(input int k);
    begin
      @(negedge clk_i);
      ev[k] = 1'b1;
      m_fl[pos[k]] = 1'b1;
      @(negedge clk_i);
      ev[k] = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial
  begin
    rv = $urandom(48);
    {m_fl, m_msk, m_tune, m_ctrl} = {16'h0000, 16'h0000, 16'h8000, 16'h08D2};
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk_outs;
    for (int a = 2; a <= 4; a++)
      rd(a[4:0]);
    for (int p = 0; p < 4; p++)
    begin
      d = 16'($urandom);
      wr(5'h04, {p[1:0], d[13:0]});
      chk_outs;
      rd(5'h04);
    end
    repeat (3)
    begin
      wr(5'h03, 16'($urandom));
      chk_outs;
      rd(5'h03);
    end
    chk("tune_start", 16'h0003, ts_cnt[15:0]);
    wr(5'h02, 16'hFFFF);
    rd(5'h02);
    wr(5'h04, 16'h1000);
    for (int k = 0; k < 6; k++)
    begin
      evt(k);
      chk_outs;
      rd(5'h02);
      chk_outs;
    end
    wr(5'h02, 16'hFF00);
    for (int k = 0; k < 6; k++)
      evt(k);
    chk_outs;
    rd(5'h02);
    // Events that arrive while the clock enable is low must leave no flag behind.
    @(negedge clk_i);
    ce = 1'b0;
    ev = 6'h3F;
    @(negedge clk_i);
    ev = 6'h00;
    ce = 1'b1;
    rd(5'h02);
    rd(5'h05);
    rd(5'h14);
    chk("unmapped_drive", 16'h0000, {15'h0000, oe_seen});
    tally_and_finish;
  end
endmodule // tcr_top_tb
